/* File: rtl/qaw_pkg.sv */
// Types of the Q&A watchdog
// Assumes qaw_regs.svh for register, field and timing constants; the phase encodings are literals here
package qaw_pkg;

	typedef enum logic [1:0] {
		QAW_WAIT   = 2'b00,
		QAW_WINDOW = 2'b01
	} qaw_phase_t;

	typedef struct packed {
		logic        watchdog_fault_pin_o;
		logic        watchdog_fault_pin_oe_n;
		logic        afterrun_abort;
		logic        afterrun_shutdown;
		logic        monitor_reset_request;
	} qaw_out_t;

endpackage

/* File: rtl/qaw_regs.svh */
// Register offsets, field positions, reset values and timing counts of the Q&A watchdog
// Assumes AXI4-Lite with 32-bit data, one aligned word per register
`ifndef QAW_REGS_SVH
`define QAW_REGS_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define QAW_QUESTION_LOW_OFS   8'h00
`define QAW_QUESTION_HIGH_OFS  8'h04
`define QAW_RESPONSE_DELAY_OFS 8'h08
`define QAW_ANSWER_BYTE_OFS    8'h0c
`define QAW_CONTROL_OFS        8'h10
`define QAW_STATUS_OFS         8'h14

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define QAW_CTRL_RST_EN_BIT    0
`define QAW_CTRL_SOFT_RST_BIT  1
`define QAW_CTRL_AFTERRUN_BIT  2
`define QAW_QHI_RESP_ERR_BIT   0
`define QAW_QHI_CHRT_BIT       1
`define QAW_QHI_WRESP_BIT      2
`define QAW_RESP_DELAY_RST     8'h3f
`define QAW_EC_RST             3'h6
`define QAW_EC_ACTIVE_MIN      3'h5
`define QAW_CNT_MAX            3'h7

// ----------------------------------------------------------------------
// Timing, in watchdog oscillator periods
// ----------------------------------------------------------------------
`define QAW_BASE_PERIODS       101
`define QAW_WINDOW_MULT        8

`endif

/* File: rtl/qaw_watchdog.sv */
// Question-and-answer watchdog with AXI4-Lite register slave
// Assumes watchdog_osc is an asynchronous oscillator pin, sampled by ref_clk
//
// Contract
// - Question readable, host reads before answering
// - Cycle starts on answer or delay write
// - Correct timely answer decrements error counter
// - Wrong, late or zero-delay answer increments
// - Only last byte timing is judged
// - Same question repeats until answered right
// - Result and next question readable afterward
// - Error counter 3 bits, resets to 6
// - Counter above 4 drives fault pin low
// - Abort counter clears when counter below 5
// - Abort counter counts overflow or soft reset
// - Abort set at 7 plus overflow or soft reset
// - Abort in after-run shuts supplies down
// - Question counter advances only on success
// - Chain steps on counter wrap after success
// - Delay write or expiry keeps question
// - Undervoltage reset zeroes counter and chain
// - Feedback top-stage XOR plus zero escape
// - Question bits mix chain and counter bits
// - Reset disabled keeps request and counter idle
// - Overflow requests reset when counter under 7
// - Reset counter counts enabled overflows, saturates
// - Wait 1+101*delay, window 8*101 periods
// - Delay resets 3f, change bumps counter
// - Byte counter from 11 picks expected byte
`timescale 1ns/1ps
`include "qaw_regs.svh"

module qaw_watchdog #(
	parameter int WAIT_BASE  = `QAW_BASE_PERIODS,
	parameter int WINDOW_LEN = `QAW_WINDOW_MULT * `QAW_BASE_PERIODS
) (
	// Clock and reset
	input  wire logic            ref_clk,
	input  wire logic            srst,
	// Watchdog oscillator pin
	input  wire logic            watchdog_osc,
	// AXI4-Lite slave
	input  wire logic [7:0]      s_axi_awaddr,
	input  wire logic            s_axi_awvalid,
	output logic                 s_axi_awready,
	input  wire logic [31:0]     s_axi_wdata,
	input  wire logic [3:0]      s_axi_wstrb,
	input  wire logic            s_axi_wvalid,
	output logic                 s_axi_wready,
	output logic [1:0]           s_axi_bresp,
	output logic                 s_axi_bvalid,
	input  wire logic            s_axi_bready,
	input  wire logic [7:0]      s_axi_araddr,
	input  wire logic            s_axi_arvalid,
	output logic                 s_axi_arready,
	output logic [31:0]          s_axi_rdata,
	output logic [1:0]           s_axi_rresp,
	output logic                 s_axi_rvalid,
	input  wire logic            s_axi_rready,
	// Watchdog outputs
	output qaw_pkg::qaw_out_t    wd_out
);
	import qaw_pkg::*;

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------
	function automatic logic [7:0] expected_answer(input logic [3:0] q, input logic [1:0] c);
		expected_answer = {q[2] ^ c[0], q[0] ^ c[0], q[3] ^ c[0], q[1] ^ c[0],
			q[2] ^ q[0] ^ q[3] ^ c[1], q[0] ^ q[3] ^ q[1] ^ c[1],
			q[2] ^ q[0] ^ q[1] ^ c[1], c[1] ^ q[3] ^ q[0]};
	endfunction

	function automatic logic [2:0] sat_inc(input logic [2:0] v);
		sat_inc = (v == `QAW_CNT_MAX) ? v : v + 3'h1;
	endfunction

	// ------------------------------------------------------------------
	// Oscillator synchroniser and tick
	// ------------------------------------------------------------------
	logic [2:0] osc_sync_r;
	logic       osc_tick;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			osc_sync_r <= 3'h0;
		end else begin
			osc_sync_r <= {osc_sync_r[1:0], watchdog_osc};
		end
	end
	assign osc_tick = osc_sync_r[1] & ~osc_sync_r[2];

	// ------------------------------------------------------------------
	// AXI4-Lite write path
	// ------------------------------------------------------------------
	logic        aw_held_r;
	logic        w_held_r;
	logic [7:0]  awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic        wr_go;

	assign wr_go = aw_held_r & w_held_r & ~s_axi_bvalid;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			aw_held_r     <= 1'b0;
			w_held_r      <= 1'b0;
			awaddr_r      <= 8'h00;
			wdata_r       <= 32'h0;
			wstrb_r       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
		end else begin
			s_axi_awready <= ~aw_held_r & ~s_axi_awready & ~s_axi_bvalid;
			s_axi_wready  <= ~w_held_r & ~s_axi_wready & ~s_axi_bvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_held_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_held_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held_r    <= 1'b0;
				w_held_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_r > `QAW_STATUS_OFS || awaddr_r[1:0] != 2'h0) ?
					2'h2 : 2'h0;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	logic wr_delay;
	logic wr_answer;
	logic wr_ctrl;

	assign wr_delay  = wr_go & (awaddr_r == `QAW_RESPONSE_DELAY_OFS) & wstrb_r[0];
	assign wr_answer = wr_go & (awaddr_r == `QAW_ANSWER_BYTE_OFS) & wstrb_r[0];
	assign wr_ctrl   = wr_go & (awaddr_r == `QAW_CONTROL_OFS) & wstrb_r[0];

	// ------------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------------
	logic monitor_reset_enable_r;
	logic afterrun_r;
	logic soft_rst;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			monitor_reset_enable_r <= 1'b0;
			afterrun_r             <= 1'b0;
		end else if (wr_ctrl) begin
			monitor_reset_enable_r <= wdata_r[`QAW_CTRL_RST_EN_BIT];
			afterrun_r             <= wdata_r[`QAW_CTRL_AFTERRUN_BIT];
		end
	end
	assign soft_rst = wr_ctrl & wdata_r[`QAW_CTRL_SOFT_RST_BIT];

	// ------------------------------------------------------------------
	// Monitoring cycle timer
	// ------------------------------------------------------------------
	qaw_phase_t  phase_r;
	logic [15:0] tmr_r;
	logic [7:0]  response_delay_r;
	logic [15:0] wait_len;
	logic        window_end;
	logic        last_byte;
	logic        seq_start;
	logic        seq_from_answer;

	assign wait_len   = 16'(1 + WAIT_BASE * int'(response_delay_r));
	assign window_end = osc_tick & (phase_r == QAW_WINDOW) &
		(tmr_r == 16'(WINDOW_LEN - 1));
	assign seq_start  = last_byte | wr_delay | window_end;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			phase_r <= QAW_WAIT;
			tmr_r   <= 16'h0;
		end else if (seq_start) begin
			phase_r <= QAW_WAIT;
			tmr_r   <= 16'h0;
		end else if (osc_tick) begin
			case (phase_r)
				QAW_WAIT: begin
					if (tmr_r >= wait_len - 16'h1) begin
						phase_r <= QAW_WINDOW;
						tmr_r   <= 16'h0;
					end else begin
						tmr_r <= tmr_r + 16'h1;
					end
				end
				QAW_WINDOW: begin
					tmr_r <= tmr_r + 16'h1;
				end
				default: begin
					phase_r <= QAW_WAIT;
					tmr_r   <= 16'h0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			response_delay_r <= `QAW_RESP_DELAY_RST;
		end else if (wr_delay) begin
			response_delay_r <= wdata_r[7:0];
		end
	end

	// ------------------------------------------------------------------
	// Question generation
	// ------------------------------------------------------------------
	logic [3:0] qcnt_r;
	logic [3:0] chain_r;
	logic [3:0] question_value;
	logic       chain_fb;
	logic       success;

	assign question_value = {chain_r[2] ^ qcnt_r[2], chain_r[0] ^ qcnt_r[0],
		chain_r[3] ^ qcnt_r[3], chain_r[1] ^ qcnt_r[1]};
	assign chain_fb = (chain_r[3] ^ chain_r[2]) | (chain_r == 4'h0);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			qcnt_r  <= 4'h0;
			chain_r <= 4'h0;
		end else if (last_byte & success) begin
			qcnt_r <= qcnt_r + 4'h1;
			if (qcnt_r == 4'hf) begin
				chain_r <= {chain_r[2:0], chain_fb};
			end
		end
	end

	// ------------------------------------------------------------------
	// Answer comparison
	// ------------------------------------------------------------------
	logic [1:0] byte_cnt_r;
	logic       resp_err_r;
	logic       byte_bad;
	logic       in_window;

	assign byte_bad  = wdata_r[7:0] != expected_answer(question_value, byte_cnt_r);
	assign last_byte = wr_answer & (byte_cnt_r == 2'h0);
	assign in_window = phase_r == QAW_WINDOW;
	assign success   = ~(resp_err_r | byte_bad) & in_window &
		(response_delay_r != 8'h0);
	assign seq_from_answer = last_byte;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			byte_cnt_r <= 2'h3;
			resp_err_r <= 1'b0;
		end else if (seq_start) begin
			byte_cnt_r <= 2'h3;
			resp_err_r <= 1'b0;
		end else if (wr_answer) begin
			byte_cnt_r <= byte_cnt_r - 2'h1;
			resp_err_r <= resp_err_r | byte_bad;
		end
	end

	// ------------------------------------------------------------------
	// Error, abort and reset counters
	// ------------------------------------------------------------------
	logic [2:0] error_counter_r;
	logic [2:0] abort_counter_r;
	logic [2:0] reset_counter_r;
	logic       afterrun_abort_r;
	logic       ec_inc;
	logic       ec_dec;
	logic       overflow;
	logic       active_int;

	assign ec_dec   = seq_from_answer & success;
	assign ec_inc   = seq_start & ~ec_dec;
	assign overflow = ec_inc & (error_counter_r == `QAW_CNT_MAX);
	assign active_int = error_counter_r >= `QAW_EC_ACTIVE_MIN;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			error_counter_r <= `QAW_EC_RST;
		end else if (overflow) begin
			error_counter_r <= `QAW_EC_RST;
		end else if (ec_inc) begin
			error_counter_r <= error_counter_r + 3'h1;
		end else if (ec_dec && error_counter_r != 3'h0) begin
			error_counter_r <= error_counter_r - 3'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			abort_counter_r  <= 3'h0;
			afterrun_abort_r <= 1'b0;
		end else if (!active_int) begin
			abort_counter_r  <= 3'h0;
			afterrun_abort_r <= 1'b0;
		end else if (overflow | soft_rst) begin
			abort_counter_r <= sat_inc(abort_counter_r);
			if (abort_counter_r == `QAW_CNT_MAX) begin
				afterrun_abort_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			reset_counter_r <= 3'h0;
		end else if (overflow & monitor_reset_enable_r) begin
			reset_counter_r <= sat_inc(reset_counter_r);
		end
	end

	// ------------------------------------------------------------------
	// Status flags and outputs
	// ------------------------------------------------------------------
	logic chrt_r;
	logic wresp_r;
	logic last_err_r;
	logic rd_qhi;

	assign rd_qhi = s_axi_arvalid & s_axi_arready & (s_axi_araddr == `QAW_QUESTION_HIGH_OFS);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			chrt_r     <= 1'b0;
			wresp_r    <= 1'b0;
			last_err_r <= 1'b0;
		end else begin
			if (wr_delay) begin
				chrt_r <= 1'b1;
			end else if (rd_qhi | last_byte | window_end) begin
				chrt_r <= 1'b0;
			end
			if (last_byte) begin
				wresp_r    <= 1'b1;
				last_err_r <= ~success;
			end else if (rd_qhi) begin
				wresp_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wd_out <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
		end else begin
			wd_out.watchdog_fault_pin_o    <= 1'b0;
			wd_out.watchdog_fault_pin_oe_n <= ~active_int;
			wd_out.afterrun_abort          <= afterrun_abort_r;
			wd_out.afterrun_shutdown       <= afterrun_abort_r & afterrun_r;
			wd_out.monitor_reset_request   <= overflow & monitor_reset_enable_r &
				(reset_counter_r != `QAW_CNT_MAX);
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite read path
	// ------------------------------------------------------------------
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h0;
		case (s_axi_araddr)
			`QAW_QUESTION_LOW_OFS:   rd_mux = {28'h0, question_value};
			`QAW_QUESTION_HIGH_OFS:  rd_mux = {29'h0, wresp_r, chrt_r, last_err_r};
			`QAW_RESPONSE_DELAY_OFS: rd_mux = {24'h0, response_delay_r};
			`QAW_CONTROL_OFS:        rd_mux = {29'h0, afterrun_r, 1'b0, monitor_reset_enable_r};
			`QAW_STATUS_OFS:         rd_mux = {20'h0, 1'b0, reset_counter_r, 1'b0,
				abort_counter_r, afterrun_abort_r, error_counter_r};
			default:                 rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= 2'h0;
		end else begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_mux;
				s_axi_rresp  <= (s_axi_araddr > `QAW_STATUS_OFS ||
					s_axi_araddr[1:0] != 2'h0) ? 2'h2 : 2'h0;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	ec_reset_six_a: assert property (@(posedge ref_clk) disable iff (srst)
		overflow |=> error_counter_r == 3'h6) else $error("error counter not 6");
	pin_active_a: assert property (@(posedge ref_clk) disable iff (srst)
		active_int |=> !wd_out.watchdog_fault_pin_oe_n) else $error("pin idle");
	abort_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
		!active_int |=> abort_counter_r == 3'h0 && !afterrun_abort_r)
		else $error("abort not cleared");
	abort_count_a: assert property (@(posedge ref_clk) disable iff (srst)
		active_int && soft_rst && abort_counter_r < 3'h7 |=>
		abort_counter_r == $past(abort_counter_r) + 3'h1) else $error("abort count");
	qcnt_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
		(wr_delay || window_end) && !last_byte |=> $stable(qcnt_r))
		else $error("question moved");
	rst_disabled_a: assert property (@(posedge ref_clk) disable iff (srst)
		!monitor_reset_enable_r |=> !wd_out.monitor_reset_request)
		else $error("reset while disabled");
	rst_sat_a: assert property (@(posedge ref_clk) disable iff (srst)
		overflow && reset_counter_r == 3'h7 |=> !wd_out.monitor_reset_request)
		else $error("reset at 7");
	zero_delay_a: assert property (@(posedge ref_clk) disable iff (srst)
		last_byte && response_delay_r == 8'h0 && error_counter_r < 3'h7 |=>
		error_counter_r == $past(error_counter_r) + 3'h1) else $error("zero delay");
endmodule

/* File: testbench/qaw_host_model.sv */
// Host controller model: AXI4-Lite master of the watchdog registers
// Assumes the bench top provides hang() for a stalled transfer
`timescale 1ns/1ps
`include "qaw_regs.svh"
module qaw_host_model (
	// Clock
	input  wire logic        clk,
	// Write channels
	output logic [7:0]       awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	// Read channels
	output logic [7:0]       araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	// ----
	// Idle state
	// ----
	initial begin
		{awaddr, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
		wstrb = 4'hf;
	end

	// ----
	// Bus cycles
	// ----
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
		input logic [3:0] s = 4'hf);
		int n;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awready) begin
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wready) begin
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		end while (bvalid !== 1'b1 && n < 64);
		r = bresp;
		bready <= 1'b0;
		if (n >= 64)
			qaw_watchdog_tb.hang();
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arready) begin
				arvalid <= 1'b0;
				araddr <= ~a;
			end
		end while (rvalid !== 1'b1 && n < 64);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n >= 64)
			qaw_watchdog_tb.hang();
	endtask

	// ----
	// Question and answer
	// ----
	task automatic ask(output logic [3:0] q);
		logic [31:0] d;
		logic [1:0]  r;
		rd(`QAW_QUESTION_LOW_OFS, d, r);
		q = d[3:0];
	endtask

	task automatic answer(input logic [31:0] v);
		logic [1:0] r;
		for (int i = 3; i >= 0; i--)
			wr(`QAW_ANSWER_BYTE_OFS, {24'h0, v[8*i+:8]}, r);
	endtask
endmodule

/* File: testbench/qaw_watchdog_tb.sv */
// Self-checking bench of the Q&A watchdog
// Assumes short timing parameters: wait 1+2*delay ticks, window 16 ticks
`timescale 1ns/1ps
`include "qaw_regs.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
	$display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end
module qaw_watchdog_tb;
	import qaw_pkg::*;
	logic              ref_clk, srst, watchdog_osc;
	logic [7:0]        awaddr, araddr;
	logic [31:0]       wdata, rdata, st, d;
	logic [3:0]        wstrb, q;
	logic [1:0]        bresp, rresp, r;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready;
	qaw_out_t          wd_out;
	int                mismatches = 0;
	int                tests_run = 0;
	int                pulses = 0;
	localparam logic [31:0] ANS [16] = '{32'hff0ff000, 32'hb040bf4f, 32'he919e616,
		32'ha656a959, 32'h75857a8a, 32'h3aca35c5, 32'h63936c9c, 32'h2cdc23d3,
		32'hd222dd2d, 32'h9d6d9262, 32'hc434cb3b, 32'h8b7b8474, 32'h58a857a7,
		32'h17e718e8, 32'h4ebe41b1, 32'h01f10efe};

	// ----
	// Clocks and instances
	// ----
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	initial begin
		watchdog_osc = 1'b0;
		#3.3;
		forever #62.5 watchdog_osc = ~watchdog_osc;
	end

	qaw_watchdog #(.WAIT_BASE(2), .WINDOW_LEN(16)) u_dut (
		.ref_clk(ref_clk), .srst(srst), .watchdog_osc(watchdog_osc),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .wd_out(wd_out)
	);

	qaw_host_model u_host (
		.clk(ref_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready)
	);

	always @(posedge ref_clk) begin
		if (srst === 1'b0 && wd_out.monitor_reset_request === 1'b1)
			pulses <= pulses + 1;
	end

	// ----
	// Helpers
	// ----
	task stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task hang;
		mismatches++;
		stop_test();
	endtask

	task ticks(input int n);
		repeat (n) @(posedge watchdog_osc);
		@(posedge ref_clk);
	endtask

	task status;
		u_host.rd(`QAW_STATUS_OFS, st, r);
	endtask

	// ----
	// Scenarios
	// ----
	task t_reset;
		u_host.wr(`QAW_RESPONSE_DELAY_OFS, 32'h5, r, 4'he);
		`CHK(r, 2'h0)
		status();
		`CHK(st[2:0], 3'h6)
		`CHK(st[6:4], 3'h0)
		`CHK(st[10:8], 3'h0)
		`CHK(st[3], 1'b0)
		`CHK(wd_out.watchdog_fault_pin_oe_n, 1'b0)
		`CHK(wd_out.watchdog_fault_pin_o, 1'b0)
		`CHK(wd_out.afterrun_shutdown, 1'b0)
		u_host.rd(`QAW_RESPONSE_DELAY_OFS, d, r);
		`CHK(d[7:0], 8'h3f)
		u_host.ask(q);
		`CHK(q, 4'h0)
		u_host.rd(8'h18, d, r);
		`CHK(r, 2'h2)
	endtask

	task t_good;
		u_host.wr(`QAW_RESPONSE_DELAY_OFS, 32'ha, r);
		status();
		`CHK(st[2:0], 3'h7)
		ticks(28);
		u_host.answer(32'hff0ff000);
		status();
		`CHK(st[2:0], 3'h6)
		u_host.rd(`QAW_QUESTION_HIGH_OFS, d, r);
		`CHK(d[0], 1'b0)
		u_host.ask(q);
		`CHK(q, 4'h4)
	endtask

	task t_wrong;
		ticks(28);
		u_host.answer(32'h0);
		status();
		`CHK(st[2:0], 3'h7)
		u_host.rd(`QAW_QUESTION_HIGH_OFS, d, r);
		`CHK(d[0], 1'b1)
		u_host.ask(q);
		`CHK(q, 4'h4)
	endtask

	task t_early;
		u_host.answer(32'h75857a8a);
		status();
		`CHK(st[2:0], 3'h6)
		`CHK(st[6:4], 3'h1)
		`CHK(st[10:8], 3'h0)
		`CHK(pulses, 0)
		u_host.ask(q);
		`CHK(q, 4'h4)
	endtask

	task t_reset_enable;
		u_host.wr(`QAW_CONTROL_OFS, 32'h1, r);
		ticks(28);
		u_host.answer(32'h75857a8a);
		status();
		`CHK(st[2:0], 3'h5)
		`CHK(wd_out.watchdog_fault_pin_oe_n, 1'b0)
		u_host.ask(q);
		`CHK(q, 4'h1)
		repeat (3) u_host.answer(32'h0);
		status();
		`CHK(st[2:0], 3'h6)
		`CHK(st[6:4], 3'h2)
		`CHK(st[10:8], 3'h1)
		`CHK(pulses, 1)
	endtask

	task t_zero_delay;
		u_host.wr(`QAW_RESPONSE_DELAY_OFS, 32'h0, r);
		ticks(6);
		u_host.answer(32'hb040bf4f);
		status();
		`CHK(st[2:0], 3'h6)
		`CHK(st[10:8], 3'h2)
		`CHK(pulses, 2)
		u_host.answer(32'hb040bf4f);
		status();
		`CHK(st[2:0], 3'h7)
	endtask

	task t_abort;
		repeat (4) u_host.wr(`QAW_CONTROL_OFS, 32'h6, r);
		status();
		`CHK(st[6:4], 3'h7)
		`CHK(st[3], 1'b0)
		u_host.wr(`QAW_CONTROL_OFS, 32'h6, r);
		status();
		`CHK(st[3], 1'b1)
		`CHK(wd_out.afterrun_abort, 1'b1)
		`CHK(wd_out.afterrun_shutdown, 1'b1)
		u_host.wr(`QAW_RESPONSE_DELAY_OFS, 32'ha, r);
		status();
		`CHK(st[2:0], 3'h6)
		`CHK(st[10:8], 3'h2)
		`CHK(pulses, 2)
		ticks(28);
		u_host.answer(32'hb040bf4f);
		u_host.ask(q);
		`CHK(q, 4'h5)
		ticks(28);
		u_host.answer(32'h3aca35c5);
		status();
		`CHK(st[2:0], 3'h4)
		`CHK(st[6:3], 4'h0)
		`CHK(wd_out.watchdog_fault_pin_oe_n, 1'b1)
		`CHK(wd_out.afterrun_shutdown, 1'b0)
	endtask

	task t_chain;
		srst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		status();
		`CHK(st[10:8], 3'h0)
		`CHK(st[2:0], 3'h6)
		u_host.ask(q);
		`CHK(q, 4'h0)
		u_host.wr(`QAW_RESPONSE_DELAY_OFS, 32'ha, r);
		u_host.rd(`QAW_QUESTION_HIGH_OFS, d, r);
		`CHK(d[1], 1'b1)
		for (int i = 0; i < 16; i++) begin
			u_host.ask(q);
			ticks(28);
			u_host.answer(ANS[q]);
			u_host.rd(`QAW_QUESTION_HIGH_OFS, d, r);
			`CHK(d[2:0], 3'h4)
		end
		u_host.ask(q);
		`CHK(q, 4'h4)
	endtask

	// ----
	// Main sequence
	// ----
	initial begin
		srst = 1'b1;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		t_reset();
		t_good();
		t_wrong();
		t_early();
		t_reset_enable();
		t_zero_delay();
		t_abort();
		t_chain();
		stop_test();
	end
endmodule
